// ### logic/ewc_write_cmd.v
// write-command handler: checks, decrypt, mac check, nvm update
//
// The register addresses and the address-and-strobe port are this design's own decisions.
`timescale 1ns/10ps
`include "ewc_map.vh"
module ewc_write_cmd (
  input wire i_clk,
  input wire i_nrst,
  input wire [7:0] i_addr,
  input wire [31:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [31:0] o_rdata,
  input wire i_cfg_locked,
  input wire i_data_locked,
  input wire [7:0] i_onetime_policy,
  input wire [15:0] i_per_slot_lock_bits,
  input wire [15:0] i_slot_settings,
  input wire [15:0] i_key_settings,
  input wire i_pubkey_validated,
  input wire [255:0] i_scratch_digest,
  input wire i_scratch_valid_flag,
  input wire i_digest_origin_flag,
  input wire [3:0] i_scratch_key_idx,
  input wire i_mac_done,
  input wire [255:0] i_mac_digest,
  input wire [31:0] i_nvm_rdata,
  output reg [3:0] o_slot_idx,
  output reg o_mac_req,
  output reg [255:0] o_mac_plain,
  output reg [7:0] o_param1,
  output reg [15:0] o_param2,
  output reg o_nvm_re,
  output reg o_nvm_we,
  output reg [1:0] o_nvm_zone,
  output reg [3:0] o_nvm_slot,
  output reg [1:0] o_nvm_blk,
  output reg [2:0] o_nvm_word,
  output reg [31:0] o_nvm_wdata,
  output reg [7:0] o_resp,
  output reg o_resp_valid,
  output reg o_busy
);
  localparam S_IDLE = 4'h0;
  localparam S_LOOK = 4'h1;
  localparam S_CHECK = 4'h2;
  localparam S_MACQ = 4'h3;
  localparam S_MACW = 4'h4;
  localparam S_WORD = 4'h5;
  localparam S_RMW = 4'h6;
  localparam S_NEXT = 4'h7;
  localparam S_INVR = 4'h8;
  localparam S_INVW = 4'h9;
  localparam S_DONE = 4'hA;

  reg [31:0] data_mem [0:7];
  reg [31:0] mac_mem [0:7];
  reg [3:0] st_r;
  reg [2:0] w_r;
  reg [2:0] wlast_r;
  reg enc_r;
  reg cons_r;
  reg inv_r;
  reg touched_r;
  reg [7:0] resp_r;
  reg [255:0] data_flat;
  reg [255:0] mac_flat;
  reg [7:0] chk_code;
  integer k;
  integer j;

  // words that really hold storage in a block; tail bytes of a partial block only feed the mac
  function [3:0] words_in;
    input [1:0] zn;
    input [3:0] slot;
    input [1:0] blk;
    begin
      words_in = 4'h8;
      if (zn == `EWC_ZONE_DATA && slot < 4'h8 && blk == 2'h1) begin
        words_in = 4'h1;
      end else if (zn == `EWC_ZONE_DATA && slot > 4'h8 && blk == 2'h2) begin
        words_in = 4'h2;
      end
    end
  endfunction

  // word-aligned address inside a buffer window
  function in_win;
    input [7:0] a;
    input [7:0] lo;
    input [7:0] hi;
    begin
      in_win = (a[1:0] == 2'h0) && (a >= lo) && (a < hi);
    end
  endfunction

  // buffer word index: both windows start two words into an eight-word period
  function [2:0] buf_idx;
    input [7:0] a;
    begin
      buf_idx = a[4:2] - 3'h2;
    end
  endfunction

  // forces the top nibble of byte zero; the stored key can then no longer pass validation
  function [31:0] patch_nib;
    input [31:0] w;
    begin
      patch_nib = {w[31:8], `EWC_INV_NIB, w[3:0]};
    end
  endfunction

  // parameter fields
  wire full = o_param1[`EWC_Z_FULL];
  wire z6 = o_param1[`EWC_Z_ENC];
  wire [1:0] zone = o_param1[1:0];
  wire [2:0] a_word = o_param2[2:0];
  wire [3:0] a_blk = o_param2[6:3];
  wire [1:0] a_dblk = o_param2[9:8];
  wire is_cfg = zone == `EWC_ZONE_CFG;
  wire is_otp = zone == `EWC_ZONE_OTP;
  wire is_data = zone == `EWC_ZONE_DATA;
  wire [1:0] tblk = is_data ? a_dblk : 2'h0;
  wire [3:0] nwords = words_in(zone, a_blk, tblk);
  wire [3:0] wp = i_slot_settings[15:12];
  wire otp_cons = i_onetime_policy == `EWC_OTP_CONS;
  wire otp_ro = i_onetime_policy == `EWC_OTP_RO;
  wire pubinfo = i_key_settings[`EWC_KS_PUBINFO];
  wire [4:0] cfg_wi = {a_blk[1:0], a_word};
  // for a data-zone write after data lock only slot bit 14 says encrypted; otherwise zone bit 6 does
  wire enc = (is_data && i_data_locked) ? i_slot_settings[`EWC_SS_ENCW] : z6;
  wire inv = is_data && a_blk >= 4'h8 && pubinfo;
  // buffer windows of the register port
  wire in_data = in_win(i_addr, `EWC_REG_DATA0, `EWC_REG_MAC0);
  wire in_mac = in_win(i_addr, `EWC_REG_MAC0, `EWC_REG_GO);

  // flattened views of the word buffers
  always @* begin
    data_flat = 256'h0;
    mac_flat = 256'h0;
    for (k = 0; k < 8; k = k + 1) begin
      data_flat[k*32 +: 32] = data_mem[k];
      mac_flat[k*32 +: 32] = mac_mem[k];
    end
  end

  // admission checks; parse faults take priority over execution faults
  always @* begin
    chk_code = `EWC_RESP_OK;
    if (o_param1[5:2] != 4'h0 || zone == 2'h3) begin
      chk_code = `EWC_RESP_PARSE;
    end else if (is_cfg && a_blk >= `EWC_CFG_BLKS) begin
      chk_code = `EWC_RESP_PARSE;
    end else if (is_otp && a_blk >= `EWC_OTP_BLKS) begin
      chk_code = `EWC_RESP_PARSE;
    end else if (is_data && a_blk < 4'h8 && {1'b0, a_dblk} >= {1'b0, `EWC_SMALL_BLKS}) begin
      chk_code = `EWC_RESP_PARSE;
    end else if (is_data && a_blk > 4'h8 && {1'b0, a_dblk} >= {1'b0, `EWC_LARGE_BLKS}) begin
      chk_code = `EWC_RESP_PARSE;
    end else if (!full && {1'b0, a_word} >= nwords) begin
      chk_code = `EWC_RESP_PARSE;
    end else if (is_cfg) begin
      if (i_cfg_locked || z6) begin
        chk_code = `EWC_RESP_EXEC;
      end else if (full ? (a_blk[1:0] == 2'h0 || a_blk[1:0] == 2'h2)
                        : (cfg_wi <= `EWC_PROT_LAST || cfg_wi == `EWC_PROT_LOCK)) begin
        chk_code = `EWC_RESP_EXEC;
      end
    end else if (!i_cfg_locked) begin
      chk_code = `EWC_RESP_EXEC;
    end else if (is_otp) begin
      if (i_data_locked && (otp_ro || z6)) begin
        chk_code = `EWC_RESP_EXEC;
      end else if (!full && !(otp_cons && !z6 && i_data_locked)) begin
        chk_code = `EWC_RESP_EXEC;
      end
    end else begin
      if (i_key_settings[`EWC_KS_PRIV] && i_key_settings[4:2] == `EWC_KT_P256) begin
        chk_code = `EWC_RESP_EXEC;
      end else if (!i_per_slot_lock_bits[a_blk]) begin
        chk_code = `EWC_RESP_EXEC;
      end else if (i_data_locked && !(wp == `EWC_WP_ALWAYS || wp == `EWC_WP_PUBINV || enc)) begin
        chk_code = `EWC_RESP_EXEC;
      end else if (pubinfo && i_pubkey_validated && wp == `EWC_WP_PUBINV) begin
        chk_code = `EWC_RESP_EXEC;
      end else if (!full && !(!i_slot_settings[`EWC_SS_SECRET] && wp == `EWC_WP_ALWAYS
                             && !z6 && i_data_locked)) begin
        chk_code = `EWC_RESP_EXEC;
      end
    end
    // scratch digest must be usable; origin and key index only matter after lock
    if (chk_code == `EWC_RESP_OK && enc) begin
      if (!i_scratch_valid_flag) begin
        chk_code = `EWC_RESP_EXEC;
      end else if (i_data_locked && is_data &&
                   (!i_digest_origin_flag || i_scratch_key_idx != i_slot_settings[11:8])) begin
        chk_code = `EWC_RESP_EXEC;
      end
    end
  end

  // register port: parameters and buffers only change while idle
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_param1 <= 8'h00;
      o_param2 <= 16'h0000;
      o_rdata <= 32'h00000000;
      for (j = 0; j < 8; j = j + 1) begin
        data_mem[j] <= 32'h00000000;
        mac_mem[j] <= 32'h00000000;
      end
    end else begin
      if (i_wr && !o_busy) begin
        if (i_addr == `EWC_REG_ZONE) begin
          o_param1 <= i_wdata[7:0];
        end else if (i_addr == `EWC_REG_ADDR) begin
          o_param2 <= i_wdata[15:0];
        end else if (in_data) begin
          data_mem[buf_idx(i_addr)] <= i_wdata;
        end else if (in_mac) begin
          mac_mem[buf_idx(i_addr)] <= i_wdata;
        end
      end
      // read data stands one cycle after the strobe; unmapped reads return zero
      o_rdata <= 32'h00000000;
      if (i_rd) begin
        if (i_addr == `EWC_REG_ZONE) begin
          o_rdata <= {24'h000000, o_param1};
        end else if (i_addr == `EWC_REG_ADDR) begin
          o_rdata <= {16'h0000, o_param2};
        end else if (in_data) begin
          o_rdata <= data_mem[buf_idx(i_addr)];
        end else if (in_mac) begin
          o_rdata <= mac_mem[buf_idx(i_addr)];
        end else if (i_addr == `EWC_REG_STAT) begin
          o_rdata <= {16'h0000, resp_r, 7'h00, o_busy};
        end
      end
    end
  end

  // command sequencer
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_r <= S_IDLE;
      w_r <= 3'h0;
      wlast_r <= 3'h0;
      enc_r <= 1'b0;
      cons_r <= 1'b0;
      inv_r <= 1'b0;
      touched_r <= 1'b0;
      resp_r <= `EWC_RESP_OK;
      o_slot_idx <= 4'h0;
      o_mac_req <= 1'b0;
      o_mac_plain <= 256'h0;
      o_nvm_re <= 1'b0;
      o_nvm_we <= 1'b0;
      o_nvm_zone <= 2'h0;
      o_nvm_slot <= 4'h0;
      o_nvm_blk <= 2'h0;
      o_nvm_word <= 3'h0;
      o_nvm_wdata <= 32'h00000000;
      o_resp <= 8'h00;
      o_resp_valid <= 1'b0;
      o_busy <= 1'b0;
    end else begin
      o_mac_req <= 1'b0;
      o_nvm_re <= 1'b0;
      o_nvm_we <= 1'b0;
      o_resp_valid <= 1'b0;
      case (st_r)
        S_IDLE: begin
          if (i_wr && i_addr == `EWC_REG_GO) begin
            o_busy <= 1'b1;
            o_slot_idx <= o_param2[6:3];
            st_r <= S_LOOK;
          end
        end
        // one cycle for the slot and key settings of the target to arrive
        S_LOOK: begin
          st_r <= S_CHECK;
        end
        S_CHECK: begin
          enc_r <= enc;
          cons_r <= is_otp && i_data_locked && otp_cons;
          inv_r <= inv;
          touched_r <= 1'b0;
          w_r <= full ? 3'h0 : a_word;
          wlast_r <= full ? nwords[2:0] - 3'h1 : a_word;
          o_nvm_zone <= zone;
          o_nvm_slot <= a_blk;
          o_nvm_blk <= tblk;
          // plaintext is recovered before any check of the mac
          o_mac_plain <= enc ? (data_flat ^ i_scratch_digest) : data_flat;
          if (chk_code != `EWC_RESP_OK) begin
            resp_r <= chk_code;
            st_r <= S_DONE;
          end else if (enc) begin
            st_r <= S_MACQ;
          end else begin
            st_r <= S_WORD;
          end
        end
        S_MACQ: begin
          o_mac_req <= 1'b1;
          st_r <= S_MACW;
        end
        S_MACW: begin
          if (i_mac_done) begin
            if (i_mac_digest != mac_flat) begin
              resp_r <= `EWC_RESP_MAC;
              st_r <= S_DONE;
            end else begin
              st_r <= S_WORD;
            end
          end
        end
        // consumption mode needs the old word first, so every write is read-modify-write
        S_WORD: begin
          o_nvm_word <= w_r;
          if (cons_r) begin
            o_nvm_re <= 1'b1;
            st_r <= S_RMW;
          end else begin
            o_nvm_we <= 1'b1;
            o_nvm_wdata <= o_mac_plain[w_r*32 +: 32];
            if (inv_r && o_nvm_blk == 2'h0 && w_r == 3'h0) begin
              o_nvm_wdata <= patch_nib(o_mac_plain[31:0]);
              touched_r <= 1'b1;
            end
            st_r <= S_NEXT;
          end
        end
        S_RMW: begin
          o_nvm_we <= 1'b1;
          o_nvm_wdata <= i_nvm_rdata & o_mac_plain[w_r*32 +: 32];
          st_r <= S_NEXT;
        end
        S_NEXT: begin
          if (w_r != wlast_r) begin
            w_r <= w_r + 3'h1;
            st_r <= S_WORD;
          end else if (inv_r && !touched_r) begin
            st_r <= S_INVR;
          end else begin
            resp_r <= `EWC_RESP_OK;
            st_r <= S_DONE;
          end
        end
        // word 0 of block 0 not written here: patch only its top nibble of byte zero
        S_INVR: begin
          o_nvm_blk <= 2'h0;
          o_nvm_word <= 3'h0;
          o_nvm_re <= 1'b1;
          st_r <= S_INVW;
        end
        S_INVW: begin
          o_nvm_we <= 1'b1;
          o_nvm_wdata <= patch_nib(i_nvm_rdata);
          resp_r <= `EWC_RESP_OK;
          st_r <= S_DONE;
        end
        S_DONE: begin
          o_resp <= resp_r;
          o_resp_valid <= 1'b1;
          o_busy <= 1'b0;
          st_r <= S_IDLE;
        end
        default: begin
          st_r <= S_IDLE;
        end
      endcase
    end
  end
endmodule

// ### logic/ewc_map.vh
// constants for the eeprom write-command handler
`ifndef EWC_MAP_VH
`define EWC_MAP_VH
// register offsets (byte addresses)
`define EWC_REG_ZONE 8'h00
`define EWC_REG_ADDR 8'h04
`define EWC_REG_DATA0 8'h08
`define EWC_REG_MAC0 8'h28
`define EWC_REG_GO 8'h48
`define EWC_REG_STAT 8'h4C
// zone-select fields
`define EWC_Z_FULL 7
`define EWC_Z_ENC 6
`define EWC_ZONE_CFG 2'h0
`define EWC_ZONE_OTP 2'h1
`define EWC_ZONE_DATA 2'h2
// slot settings / key settings fields
`define EWC_SS_SECRET 7
`define EWC_SS_ENCW 14
`define EWC_KS_PRIV 0
`define EWC_KS_PUBINFO 1
`define EWC_KT_P256 3'h4
`define EWC_WP_ALWAYS 4'h0
`define EWC_WP_PUBINV 4'h1
// one-time policy byte values
`define EWC_OTP_RO 8'hAA
`define EWC_OTP_CONS 8'h55
// zone and data-slot sizes in blocks
`define EWC_CFG_BLKS 4'h4
`define EWC_OTP_BLKS 4'h2
`define EWC_SMALL_BLKS 2'h2
`define EWC_LARGE_BLKS 2'h3
// permanently protected config words (block*8+word)
`define EWC_PROT_LAST 5'h03
`define EWC_PROT_LOCK 5'h15
// answers
`define EWC_RESP_OK 8'h00
`define EWC_RESP_MAC 8'h01
`define EWC_RESP_PARSE 8'h03
`define EWC_RESP_EXEC 8'h0F
`define EWC_INV_NIB 4'hA
`endif

// ### tb/ewc_far_model.sv
// nvm array and mac engine seen from the write-command handler
`timescale 1ns/10ps
module ewc_far_model (
  input wire logic i_clk,
  input wire logic i_nvm_re,
  input wire logic i_nvm_we,
  input wire logic [10:0] i_nvm_addr,
  input wire logic [31:0] i_nvm_wdata,
  input wire logic i_mac_req,
  input wire logic [255:0] i_mac_plain,
  output logic [31:0] o_nvm_rdata,
  output logic o_mac_done,
  output logic [255:0] o_mac_digest
);
  logic [31:0] mem [0:2047];
  logic [2:0] mac_cnt;
  initial begin
    mac_cnt = 3'h0;
    o_mac_done = 1'b0;
  end
  // read word shows while the read strobe stands, inverted otherwise so a stray sample is caught
  assign o_nvm_rdata = i_nvm_re ? mem[i_nvm_addr] : ~mem[i_nvm_addr];
  always @(posedge i_clk) begin
    if (i_nvm_we)
      mem[i_nvm_addr] <= i_nvm_wdata;
    o_mac_done <= (mac_cnt == 3'h1);
    // stand-in hash: digest equals the plaintext, finished a few cycles late
    o_mac_digest <= i_mac_plain;
    if (i_mac_req)
      mac_cnt <= 3'h4;
    else if (mac_cnt != 3'h0)
      mac_cnt <= mac_cnt - 3'h1;
  end
endmodule

// ### tb/ewc_write_cmd_sva.sv
// assertions on the ports of the write-command handler
`timescale 1ns/10ps
module ewc_write_cmd_sva (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [7:0] i_addr,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic i_cfg_locked,
  input wire logic [15:0] i_per_slot_lock_bits,
  input wire logic [7:0] o_param1,
  input wire logic [15:0] o_param2,
  input wire logic o_mac_req,
  input wire logic o_nvm_we,
  input wire logic [7:0] o_resp,
  input wire logic o_resp_valid,
  input wire logic o_busy
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);
  // go written while idle
  sequence s_go;
    i_wr && i_addr == 8'h48 && !o_busy;
  endsequence
  // refusal: nothing stored, error byte four edges after go
  sequence s_refuse;
    (!o_nvm_we) [*4] ##1 (o_resp_valid && o_resp != 8'h00);
  endsequence
  chk_busy_rise: assert property (s_go |=> o_busy) else $error("busy did not rise after go");
  chk_resv_bits: assert property (
    s_go ##0 o_param1[5:2] != 4'h0 |-> ##4 o_resp_valid && o_resp == 8'h03) else $error("reserved bits accepted");
  chk_cfg_lock: assert property (
    s_go ##0 o_param1[5:0] == 6'h00 && (i_cfg_locked || o_param1[6]) |-> s_refuse) else $error("config write taken");
  chk_cfg_first: assert property (
    s_go ##0 o_param1[5:2] == 4'h0 && o_param1[1:0] != 2'h0 && !i_cfg_locked |-> s_refuse)
    else $error("write before config lock");
  chk_slot_lock: assert property (
    s_go ##0 o_param1[5:0] == 6'h02 && !i_per_slot_lock_bits[o_param2[6:3]] |-> s_refuse)
    else $error("locked slot written");
  chk_we_busy: assert property (o_nvm_we |-> o_busy) else $error("nvm write while idle");
  chk_answer_end: assert property (o_resp_valid |-> !o_busy && $past(o_busy)) else $error("answer outside command");
  chk_mac_pulse: assert property (o_mac_req |=> !o_mac_req && o_busy) else $error("mac request not a pulse");
  chk_rd_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h0) else $error("read data without read");
endmodule
bind ewc_write_cmd ewc_write_cmd_sva u_ewc_write_cmd_sva (.i_clk(i_clk), .i_nrst(i_nrst), .i_addr(i_addr),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_cfg_locked(i_cfg_locked),
  .i_per_slot_lock_bits(i_per_slot_lock_bits), .o_param1(o_param1), .o_param2(o_param2), .o_mac_req(o_mac_req),
  .o_nvm_we(o_nvm_we), .o_resp(o_resp), .o_resp_valid(o_resp_valid), .o_busy(o_busy));

// ### tb/ewc_write_cmd_tb.sv
// self-checking testbench for the write-command handler
`timescale 1ns/10ps
`include "ewc_map.vh"
module ewc_write_cmd_tb;
  logic i_clk, i_nrst, i_wr, i_rd, i_cfg_locked, i_data_locked, i_scratch_valid_flag;
  logic [7:0] i_addr;
  logic [31:0] i_wdata;
  logic [15:0] i_per_slot_lock_bits;
  logic [255:0] i_scratch_digest;
  logic [7:0] i_onetime_policy;
  logic i_pubkey_validated;
  logic [31:0] pbase;
  logic [15:0] ss [16];
  logic [15:0] ks [16];
  wire [31:0] o_rdata, o_nvm_wdata, nvm_rdata;
  wire [255:0] o_mac_plain, mac_digest;
  wire [15:0] o_param2;
  wire [7:0] o_param1, o_resp;
  wire [3:0] o_slot_idx, o_nvm_slot;
  wire [2:0] o_nvm_word;
  wire [1:0] o_nvm_zone, o_nvm_blk;
  wire o_mac_req, o_nvm_re, o_nvm_we, o_resp_valid, o_busy, mac_done;
  int n_mismatch, samples_checked, n_we;
  ewc_write_cmd u_ewc_write_cmd (.i_clk(i_clk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_cfg_locked(i_cfg_locked), .i_data_locked(i_data_locked),
    .i_onetime_policy(i_onetime_policy), .i_per_slot_lock_bits(i_per_slot_lock_bits),
    .i_slot_settings(ss[o_slot_idx]), .i_key_settings(ks[o_slot_idx]),
    .i_pubkey_validated(i_pubkey_validated), .i_scratch_digest(i_scratch_digest),
    .i_scratch_valid_flag(i_scratch_valid_flag), .i_digest_origin_flag(1'b1), .i_scratch_key_idx(4'h0),
    .i_mac_done(mac_done), .i_mac_digest(mac_digest), .i_nvm_rdata(nvm_rdata), .o_slot_idx(o_slot_idx),
    .o_mac_req(o_mac_req), .o_mac_plain(o_mac_plain), .o_param1(o_param1), .o_param2(o_param2),
    .o_nvm_re(o_nvm_re), .o_nvm_we(o_nvm_we), .o_nvm_zone(o_nvm_zone), .o_nvm_slot(o_nvm_slot),
    .o_nvm_blk(o_nvm_blk), .o_nvm_word(o_nvm_word), .o_nvm_wdata(o_nvm_wdata), .o_resp(o_resp),
    .o_resp_valid(o_resp_valid), .o_busy(o_busy));
  ewc_far_model u_ewc_far_model (.i_clk(i_clk), .i_nvm_re(o_nvm_re), .i_nvm_we(o_nvm_we),
    .i_nvm_addr({o_nvm_zone, o_nvm_slot, o_nvm_blk, o_nvm_word}), .i_nvm_wdata(o_nvm_wdata),
    .i_mac_req(o_mac_req), .i_mac_plain(o_mac_plain), .o_nvm_rdata(nvm_rdata), .o_mac_done(mac_done),
    .o_mac_digest(mac_digest));
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  // count nvm strobes so a refusal can prove that nothing was stored
  always @(posedge i_clk) begin
    if (o_nvm_we === 1'b1)
      n_we <= n_we + 1;
  end
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one-cycle strobes with a gap, so a strobe is never assigned twice in one step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask
  // load parameters, payload and mac, fire, then judge answer and store count
  task automatic cmd(input logic [7:0] p1, input logic [15:0] p2, input logic enc, input logic good,
    input logic [7:0] exp, input int exp_we);
    logic [31:0] pw;
    int we0;
    we0 = n_we;
    wr(`EWC_REG_ZONE, {24'h0, p1});
    wr(`EWC_REG_ADDR, {16'h0, p2});
    for (int n = 0; n < 8; n++) begin
      pw = pbase + n;
      wr(8'h08 + 8'(n * 4), enc ? pw ^ i_scratch_digest[n * 32 +: 32] : pw);
      wr(8'h28 + 8'(n * 4), good ? pw : ~pw);
    end
    wr(`EWC_REG_GO, 32'h0);
    for (int t = 0; t < 200 && o_resp_valid !== 1'b1; t++) begin
      @(posedge i_clk);
      #1;
    end
    if (o_resp_valid !== 1'b1) begin
      n_mismatch++;
      end_of_test();
    end
    check({24'h0, o_resp}, {24'h0, exp});
    check(n_we - we0, exp_we);
  endtask
  task automatic t_regs();
    logic [31:0] d;
    rd(`EWC_REG_STAT, d);
    check(d, 32'h0);
    rd(8'h80, d);
    check(d, 32'h0);
  endtask
  task automatic t_cfg();
    cmd(8'h80, 16'h0008, 1'b0, 1'b1, `EWC_RESP_OK, 8);
    cmd(8'h04, 16'h0008, 1'b0, 1'b1, `EWC_RESP_PARSE, 0);
    cmd(8'h00, 16'h0000, 1'b0, 1'b1, `EWC_RESP_EXEC, 0);
    cmd(8'hC0, 16'h0008, 1'b1, 1'b1, `EWC_RESP_EXEC, 0);
    cmd(8'h82, 16'h0000, 1'b0, 1'b1, `EWC_RESP_EXEC, 0);
    @(posedge i_clk);
    i_cfg_locked <= 1'b1;
    cmd(8'h80, 16'h0008, 1'b0, 1'b1, `EWC_RESP_EXEC, 0);
  endtask
  task automatic t_data_open();
    cmd(8'hC2, 16'h0000, 1'b1, 1'b1, `EWC_RESP_OK, 8);
    check(u_ewc_far_model.mem[11'h400], 32'hC0DE0000);
    cmd(8'hC2, 16'h0000, 1'b1, 1'b0, `EWC_RESP_MAC, 0);
    cmd(8'h81, 16'h0000, 1'b0, 1'b1, `EWC_RESP_OK, 8);
    cmd(8'h01, 16'h0000, 1'b0, 1'b1, `EWC_RESP_EXEC, 0);
    @(posedge i_clk);
    i_scratch_valid_flag <= 1'b0;
    cmd(8'hC2, 16'h0000, 1'b1, 1'b1, `EWC_RESP_EXEC, 0);
    @(posedge i_clk);
    i_scratch_valid_flag <= 1'b1;
    i_per_slot_lock_bits <= 16'hFFDF;
    ks[6] <= 16'h0011;
    cmd(8'h82, 16'h0028, 1'b0, 1'b1, `EWC_RESP_EXEC, 0);
    cmd(8'h82, 16'h0030, 1'b0, 1'b1, `EWC_RESP_EXEC, 0);
  endtask
  task automatic t_data_locked();
    @(posedge i_clk);
    i_data_locked <= 1'b1;
    ss[4] <= 16'h0080;
    ss[7] <= 16'h2000;
    ks[9] <= 16'h0012;
    ss[10] <= 16'h4000;
    cmd(8'h02, 16'h0019, 1'b0, 1'b1, `EWC_RESP_OK, 1);
    cmd(8'h02, 16'h0021, 1'b0, 1'b1, `EWC_RESP_EXEC, 0);
    cmd(8'h82, 16'h0038, 1'b0, 1'b1, `EWC_RESP_EXEC, 0);
    cmd(8'h82, 16'h0200, 1'b0, 1'b1, `EWC_RESP_PARSE, 0);
    cmd(8'hC1, 16'h0000, 1'b1, 1'b1, `EWC_RESP_EXEC, 0);
    cmd(8'h82, 16'h0148, 1'b0, 1'b1, `EWC_RESP_OK, 9);
    check({28'h0, u_ewc_far_model.mem[11'h520][7:4]}, 32'hA);
    cmd(8'h82, 16'h0050, 1'b1, 1'b1, `EWC_RESP_OK, 8);
    check(u_ewc_far_model.mem[11'h540], 32'hC0DE0000);
    cmd(8'h82, 16'h0108, 1'b0, 1'b1, `EWC_RESP_OK, 1);
    pbase = 32'h3CF00000;
    cmd(8'h01, 16'h0000, 1'b0, 1'b1, `EWC_RESP_OK, 1);
    check(u_ewc_far_model.mem[11'h200], 32'h00D00000);
    pbase = 32'hC0DE0000;
    @(posedge i_clk);
    i_onetime_policy <= 8'hAA;
    i_pubkey_validated <= 1'b1;
    ss[9] <= 16'h1000;
    cmd(8'h01, 16'h0000, 1'b0, 1'b1, `EWC_RESP_EXEC, 0);
    cmd(8'h82, 16'h0148, 1'b0, 1'b1, `EWC_RESP_EXEC, 0);
  endtask
  initial begin
    i_nrst = 1'b0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 8'h00;
    i_wdata = 32'h0;
    i_cfg_locked = 1'b0;
    i_data_locked = 1'b0;
    i_scratch_valid_flag = 1'b1;
    i_per_slot_lock_bits = 16'hFFFF;
    i_scratch_digest = {8{32'h3C96A55A}};
    i_onetime_policy = 8'h55;
    i_pubkey_validated = 1'b0;
    pbase = 32'hC0DE0000;
    for (int s = 0; s < 16; s++) begin
      ss[s] = 16'h0000;
      ks[s] = 16'h0000;
    end
    repeat (6) @(posedge i_clk);
    i_nrst <= 1'b1;
    t_regs();
    t_cfg();
    t_data_open();
    t_data_locked();
    end_of_test();
  end
endmodule
